// *** rtl/act_pkg.sv ***
// Package: register map, field positions and codes for the converter control
package act_pkg;

	// ------------------------------------------------------------------
	// Register byte addresses (word aligned)
	// ------------------------------------------------------------------
	localparam logic [7:0] ACT_OFS_CTRL0    = 8'h00;
	localparam logic [7:0] ACT_OFS_SRCCLK   = 8'h04;
	localparam logic [7:0] ACT_OFS_AMPREF   = 8'h08;
	localparam logic [7:0] ACT_OFS_TRIG     = 8'h0C;
	localparam logic [7:0] ACT_OFS_DELAY    = 8'h10;
	localparam logic [7:0] ACT_OFS_RES_LO   = 8'h14;
	localparam logic [7:0] ACT_OFS_RES_HI   = 8'h18;
	localparam logic [7:0] ACT_OFS_LOWB_LO  = 8'h1C;
	localparam logic [7:0] ACT_OFS_LOWB_HI  = 8'h20;
	localparam logic [7:0] ACT_OFS_HIGHB_LO = 8'h24;
	localparam logic [7:0] ACT_OFS_HIGHB_HI = 8'h28;
	localparam logic [7:0] ACT_OFS_STATUS   = 8'h2C;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] ACT_RST_BYTE = 8'h00;

	// ------------------------------------------------------------------
	// Read masks of implemented bits
	// ------------------------------------------------------------------
	localparam logic [7:0] ACT_MSK_CTRL0  = 8'hBF;  // busy bit is read only
	localparam logic [7:0] ACT_MSK_SRCCLK = 8'hE7;
	localparam logic [7:0] ACT_MSK_AMPREF = 8'h9F;
	localparam logic [7:0] ACT_MSK_TRIG   = 8'hFB;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int ACT_B_START   = 7;
	localparam int ACT_B_BUSY    = 6;
	localparam int ACT_B_ENABLE  = 5;
	localparam int ACT_B_JUSTIFY = 4;
	localparam int ACT_B_AMPEN   = 7;
	localparam int ACT_B_AMPIN   = 4;
	localparam int ACT_B_TRGSRC  = 7;
	localparam int ACT_B_DLYEN   = 6;
	localparam int ACT_B_PWMSEL  = 5;

	// ------------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------------
	localparam logic [2:0] ACT_SRC_EXT   = 3'h0;
	localparam logic [2:0] ACT_SRC_OPAMP = 3'h1;
	localparam logic [1:0] ACT_CMP_INSIDE = 2'h0;
	localparam logic [1:0] ACT_CMP_LOW    = 2'h1;
	localparam logic [1:0] ACT_CMP_HIGH   = 2'h2;
	localparam logic [3:0] ACT_CH_LAST    = 4'h9;

	// Analog steering toward the converter core
	typedef struct packed {
		logic [9:0] channel_onehot;   // external inputs 0..9, none floats
		logic [2:0] source_code;      // internal source selection
		logic [1:0] reference_code;   // reference selection
		logic       ext_ref_pin_on;   // external reference pin connected
		logic       amp_ref_pin_on;   // amplifier reference-input pin on
		logic       bandgap_to_amp;   // bandgap feeds amplifier
		logic       amp_enable;       // gain amplifier powered
		logic [1:0] gain_code;        // amplifier gain
		logic [2:0] clk_div_code;     // conversion clock divider
	} act_analog_t;

	// Handshake with the converter core
	typedef struct packed {
		logic        start;           // one-cycle conversion start
		logic        core_enable;     // converter powered
	} act_core_req_t;

	typedef struct packed {
		logic        done;            // one-cycle end of conversion
		logic [11:0] result;          // right-aligned result
	} act_core_rsp_t;

endpackage : act_pkg

// *** rtl/act_top.sv ***
// Converter control and trigger logic with a classic Wishbone slave
// ----------------------------------------------------------------------
// Summary of operation
// - Justify bit places result high or low
// - Channel code picks external input or floats
// - Source code picks external or internal signal
// - Internal source disconnects external channel path
// - Conversion clock is system clock over 2^code
// - Amplifier input pin or bandgap, bandgap disconnects pin
// - Reference select; non-pin choice disconnects pin
// - Gain code selects four amplifier gains
// - Trigger bit picks software start or PWM
// - Event bit picks period or duty match
// - Compare mode flags result against bounds, only with the op-amp source selected
// - Duty channel field picks PWM channel
// - Delay equals count times clock period
// - Delay starts on rising PWM flag edge
// - Unimplemented bits read as zero
// - Start bit high then low starts conversion
// - Busy flag set at start, cleared at end
// - Completion sets converter request flag
// ----------------------------------------------------------------------
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

module act_top
	import act_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          cyc_i,
	input  wire logic          stb_i,
	input  wire logic          we_i,
	input  wire logic [7:0]    adr_i,
	input  wire logic [3:0]    sel_i,
	input  wire logic [31:0]   dat_i,
	output logic      [31:0]   dat_o,
	output logic               ack_o,
	output logic               err_o,
	input  wire logic          pwm_period_flag_i,
	input  wire logic [2:0]    pwm_duty_flag_i,
	input  wire act_core_rsp_t core_rsp_i,
	output act_core_req_t      core_req_o,
	output act_analog_t        analog_o,
	output logic               conv_clk_o,
	output logic               conversion_done_o,
	output logic               compare_hit_o
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0]  ctrl0_ff;        // start, enable, justify, channel
	logic [7:0]  srcclk_ff;
	logic [7:0]  ampref_ff;
	logic [7:0]  trig_ff;
	logic [7:0]  delay_ff;
	logic [11:0] low_bound_ff;
	logic [11:0] high_bound_ff;
	logic [11:0] result_ff;
	logic        busy_ff;
	logic        done_flag_ff;
	logic        cmp_flag_ff;
	logic        ack_ff;
	logic        err_ff;
	logic [31:0] dat_ff;
	logic        evt_prev_ff;
	logic        dly_run_ff;
	logic [7:0]  dly_cnt_ff;
	logic [6:0]  div_cnt_ff;
	logic        conv_clk_ff;
	logic        start_ff;
	logic        done_ff;
	logic        cmp_hit_ff;

	logic        bus_req;
	logic        wr_lo;
	logic        hit;
	logic [7:0]  nxt_rd;
	logic        sw_start;
	logic        pwm_evt;
	logic        evt_rise;
	logic        pwm_start;
	logic        fire;
	logic        cmp_now;
	logic [11:0] res_new;
	logic [1:0]  cmp_mode;

	// ------------------------------------------------------------------
	// Wishbone decode: one wait state, ack for one cycle
	// ------------------------------------------------------------------
	assign bus_req = cyc_i & stb_i & ~ack_ff & ~err_ff;
	assign wr_lo   = bus_req & we_i & sel_i[0] & hit;
	assign cmp_mode = trig_ff[4:3];

	// Read mux, unimplemented bits masked to zero
	always_comb begin
		hit    = 1'b1;
		nxt_rd = 8'h00;
		unique case (adr_i)
			ACT_OFS_CTRL0:    nxt_rd = (ctrl0_ff & ACT_MSK_CTRL0)
				| {1'b0, busy_ff, 6'h00};
			ACT_OFS_SRCCLK:   nxt_rd = srcclk_ff & ACT_MSK_SRCCLK;
			ACT_OFS_AMPREF:   nxt_rd = ampref_ff & ACT_MSK_AMPREF;
			ACT_OFS_TRIG:     nxt_rd = trig_ff & ACT_MSK_TRIG;
			ACT_OFS_DELAY:    nxt_rd = delay_ff;
			// Low byte by justify
			ACT_OFS_RES_LO:   nxt_rd = ctrl0_ff[ACT_B_JUSTIFY]
				? result_ff[7:0] : {result_ff[3:0], 4'h0};
			ACT_OFS_RES_HI:   nxt_rd = ctrl0_ff[ACT_B_JUSTIFY]
				? {4'h0, result_ff[11:8]} : result_ff[11:4];
			ACT_OFS_LOWB_LO:  nxt_rd = ctrl0_ff[ACT_B_JUSTIFY]
				? low_bound_ff[7:0] : {low_bound_ff[3:0], 4'h0};
			ACT_OFS_LOWB_HI:  nxt_rd = ctrl0_ff[ACT_B_JUSTIFY]
				? {4'h0, low_bound_ff[11:8]} : low_bound_ff[11:4];
			ACT_OFS_HIGHB_LO: nxt_rd = ctrl0_ff[ACT_B_JUSTIFY]
				? high_bound_ff[7:0] : {high_bound_ff[3:0], 4'h0};
			ACT_OFS_HIGHB_HI: nxt_rd = ctrl0_ff[ACT_B_JUSTIFY]
				? {4'h0, high_bound_ff[11:8]} : high_bound_ff[11:4];
			ACT_OFS_STATUS:   nxt_rd = {6'h00, cmp_flag_ff, done_flag_ff};
			default:          hit = 1'b0;
		endcase
	end

	// Bus answer: ack on mapped address, err otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			err_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req & hit;
			err_ff <= bus_req & ~hit;
			dat_ff <= {24'h00_0000, nxt_rd};
		end
	end

	assign ack_o = ack_ff;
	assign err_o = err_ff;
	assign dat_o = dat_ff;

	// ------------------------------------------------------------------
	// Control register writes
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0_ff  <= ACT_RST_BYTE;
			srcclk_ff <= ACT_RST_BYTE;
			ampref_ff <= ACT_RST_BYTE;
			trig_ff   <= ACT_RST_BYTE;
			delay_ff  <= ACT_RST_BYTE;
		end else if (wr_lo) begin
			unique case (adr_i)
				ACT_OFS_CTRL0:  ctrl0_ff  <= dat_i[7:0] & ACT_MSK_CTRL0;
				ACT_OFS_SRCCLK: srcclk_ff <= dat_i[7:0] & ACT_MSK_SRCCLK;
				ACT_OFS_AMPREF: ampref_ff <= dat_i[7:0] & ACT_MSK_AMPREF;
				ACT_OFS_TRIG:   trig_ff   <= dat_i[7:0] & ACT_MSK_TRIG;
				ACT_OFS_DELAY:  delay_ff  <= dat_i[7:0];
				default:        ;
			endcase
		end
	end

	// Boundary values are written only while enabled, bytes placed by justify
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_bound_ff  <= 12'h000;
			high_bound_ff <= 12'h000;
		end else if (wr_lo && ctrl0_ff[ACT_B_ENABLE]) begin
			unique case (adr_i)
				ACT_OFS_LOWB_LO: low_bound_ff <= ctrl0_ff[ACT_B_JUSTIFY]
					? {low_bound_ff[11:8], dat_i[7:0]}
					: {low_bound_ff[11:4], dat_i[7:4]};
				ACT_OFS_LOWB_HI: low_bound_ff <= ctrl0_ff[ACT_B_JUSTIFY]
					? {dat_i[3:0], low_bound_ff[7:0]}
					: {dat_i[7:0], low_bound_ff[3:0]};
				ACT_OFS_HIGHB_LO: high_bound_ff <= ctrl0_ff[ACT_B_JUSTIFY]
					? {high_bound_ff[11:8], dat_i[7:0]}
					: {high_bound_ff[11:4], dat_i[7:4]};
				ACT_OFS_HIGHB_HI: high_bound_ff <= ctrl0_ff[ACT_B_JUSTIFY]
					? {dat_i[3:0], high_bound_ff[7:0]}
					: {dat_i[7:0], high_bound_ff[3:0]};
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Trigger path
	// ------------------------------------------------------------------
	// Start bit falling by a write completes the pulse
	assign sw_start = wr_lo && (adr_i == ACT_OFS_CTRL0)
		&& ctrl0_ff[ACT_B_START] && !dat_i[ACT_B_START];

	// Period or chosen duty flag
	always_comb begin
		if (!trig_ff[ACT_B_PWMSEL]) begin
			pwm_evt = pwm_period_flag_i;
		end else begin
			unique case (trig_ff[1:0])
				2'b00:   pwm_evt = pwm_duty_flag_i[0];
				2'b01:   pwm_evt = pwm_duty_flag_i[1];
				default: pwm_evt = pwm_duty_flag_i[2];
			endcase
		end
	end

	assign evt_rise = pwm_evt & ~evt_prev_ff;

	// Delay counter; a count of N gives N cycles before the start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_prev_ff <= 1'b0;
			dly_run_ff  <= 1'b0;
			dly_cnt_ff  <= 8'h00;
		end else begin
			evt_prev_ff <= pwm_evt;
			if (evt_rise && trig_ff[ACT_B_DLYEN] && delay_ff != 8'h00) begin
				dly_run_ff <= 1'b1;
				dly_cnt_ff <= delay_ff - 8'h01;
			end else if (dly_run_ff) begin
				if (dly_cnt_ff == 8'h00) begin
					dly_run_ff <= 1'b0;
				end else begin
					dly_cnt_ff <= dly_cnt_ff - 8'h01;
				end
			end
		end
	end

	// Delay of zero with delay enabled behaves as undelayed
	assign pwm_start = (dly_run_ff && dly_cnt_ff == 8'h00)
		|| (evt_rise && (!trig_ff[ACT_B_DLYEN] || delay_ff == 8'h00));
	assign fire = ctrl0_ff[ACT_B_ENABLE] && !busy_ff
		&& (trig_ff[ACT_B_TRGSRC] ? pwm_start : sw_start);

	// Single-cycle start toward the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_ff <= 1'b0;
		end else begin
			start_ff <= fire;
		end
	end

	// Busy set at start, cleared on done; the start wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff <= 1'b0;
		end else if (fire) begin
			busy_ff <= 1'b1;
		end else if (core_rsp_i.done) begin
			busy_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Completion, result and compare
	// ------------------------------------------------------------------
	assign res_new = core_rsp_i.result;

	// Compare on the right-aligned new result
	always_comb begin
		unique case (cmp_mode)
			ACT_CMP_INSIDE: cmp_now = (res_new > low_bound_ff)
				&& (res_new < high_bound_ff);
			ACT_CMP_LOW:    cmp_now = res_new <= low_bound_ff;
			ACT_CMP_HIGH:   cmp_now = res_new >= high_bound_ff;
			default:        cmp_now = (res_new <= low_bound_ff)
				|| (res_new >= high_bound_ff);
		endcase
	end

	// Result stored only while enabled; flags set over a W1C clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_ff    <= 12'h000;
			done_flag_ff <= 1'b0;
			cmp_flag_ff  <= 1'b0;
			done_ff      <= 1'b0;
			cmp_hit_ff   <= 1'b0;
		end else begin
			done_ff    <= core_rsp_i.done & busy_ff;
			cmp_hit_ff <= core_rsp_i.done & busy_ff & cmp_now
				& (srcclk_ff[7:5] == ACT_SRC_OPAMP);
			if (core_rsp_i.done && busy_ff && ctrl0_ff[ACT_B_ENABLE]) begin
				result_ff <= res_new;
			end
			if (done_ff) begin
				done_flag_ff <= 1'b1;
			end else if (wr_lo && adr_i == ACT_OFS_STATUS && dat_i[0]) begin
				done_flag_ff <= 1'b0;
			end
			if (cmp_hit_ff) begin
				cmp_flag_ff <= 1'b1;
			end else if (wr_lo && adr_i == ACT_OFS_STATUS && dat_i[1]) begin
				cmp_flag_ff <= 1'b0;
			end
		end
	end

	assign conversion_done_o = done_ff;
	assign compare_hit_o     = cmp_hit_ff;

	// ------------------------------------------------------------------
	// Conversion clock: 2^code division of the system clock
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_ff  <= 7'h00;
			conv_clk_ff <= 1'b0;
		end else begin
			div_cnt_ff <= div_cnt_ff + 7'h01;
			// Code 0 passes the system clock rate as an enable pulse
			conv_clk_ff <= (srcclk_ff[2:0] == 3'h0) ? 1'b1
				: div_cnt_ff[srcclk_ff[2:0] - 3'h1];
		end
	end

	assign conv_clk_o = conv_clk_ff;

	// ------------------------------------------------------------------
	// Analog steering
	// ------------------------------------------------------------------
	always_comb begin
		analog_o = '0;
		// Internal source isolates every external input
		if (srcclk_ff[7:5] == ACT_SRC_EXT && ctrl0_ff[3:0] <= ACT_CH_LAST
			&& ctrl0_ff[3:0] != 4'h1) begin
			analog_o.channel_onehot[ctrl0_ff[3:0]] = 1'b1;
		end
		analog_o.source_code    = srcclk_ff[7:5];
		analog_o.reference_code = ampref_ff[3:2];
		analog_o.ext_ref_pin_on = ampref_ff[3:2] == 2'b01;
		analog_o.bandgap_to_amp = ampref_ff[ACT_B_AMPIN];
		analog_o.amp_ref_pin_on = !ampref_ff[ACT_B_AMPIN];
		analog_o.amp_enable     = ampref_ff[ACT_B_AMPEN];
		analog_o.gain_code      = ampref_ff[1:0];
		analog_o.clk_div_code   = srcclk_ff[2:0];
	end

	assign core_req_o.start       = start_ff;
	assign core_req_o.core_enable = ctrl0_ff[ACT_B_ENABLE];

endmodule : act_top

// *** dv/act_top_props.sv ***
// Checker of the converter control ports
`timescale 1ns/1ps

module act_top_props
	import act_pkg::*;
(
	input wire logic          clk_i,
	input wire logic          rst_i,
	input wire logic          err_o,
	input wire act_core_req_t core_req_o,
	input wire act_core_rsp_t core_rsp_i,
	input wire act_analog_t   analog_o,
	input wire logic          conv_clk_o,
	input wire logic          conversion_done_o,
	input wire logic          compare_hit_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------------
	// Analog steering
	// ------------------------------------------------------------------
	property p_chan;
		$onehot0(analog_o.channel_onehot) && !analog_o.channel_onehot[1];
	endproperty
	a_chan: assert property (p_chan) else $error("bad channel");
	// Two sources must never be joined on the converter input
	property p_iso;
		analog_o.source_code != ACT_SRC_EXT
			|-> analog_o.channel_onehot == 10'h000;
	endproperty
	a_iso: assert property (p_iso) else $error("channel not off");
	property p_ampin;
		analog_o.amp_ref_pin_on == !analog_o.bandgap_to_amp;
	endproperty
	a_ampin: assert property (p_ampin) else $error("amp pin");
	property p_refpin;
		analog_o.ext_ref_pin_on == (analog_o.reference_code == 2'h1);
	endproperty
	a_refpin: assert property (p_refpin) else $error("ref pin");

	// ------------------------------------------------------------------
	// Conversion clock, start and completion
	// ------------------------------------------------------------------
	// Two cycles of code 0, so the edge that leaves reset is not judged
	property p_div0;
		analog_o.clk_div_code == 3'h0 ##1 analog_o.clk_div_code == 3'h0
			|=> conv_clk_o;
	endproperty
	a_div0: assert property (p_div0) else $error("clock not high");
	property p_div1;
		analog_o.clk_div_code == 3'h1 ##1 analog_o.clk_div_code == 3'h1
			|=> conv_clk_o != $past(conv_clk_o);
	endproperty
	a_div1: assert property (p_div1) else $error("clock not halved");
	property p_start;
		core_req_o.start |=> !core_req_o.start;
	endproperty
	a_start: assert property (p_start) else $error("long start");
	property p_done;
		conversion_done_o |-> $past(core_rsp_i.done);
	endproperty
	a_done: assert property (p_done) else $error("done no cause");
	property p_hit;
		compare_hit_o |-> conversion_done_o
			&& $past(analog_o.source_code) == ACT_SRC_OPAMP;
	endproperty
	a_hit: assert property (p_hit) else $error("stray hit");

	c_start: cover property (core_req_o.start);
	c_hit: cover property (compare_hit_o);
	c_err: cover property (err_o);
endmodule : act_top_props

bind act_top act_top_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .err_o(err_o), .core_req_o(core_req_o),
	.core_rsp_i(core_rsp_i), .analog_o(analog_o), .conv_clk_o(conv_clk_o),
	.conversion_done_o(conversion_done_o), .compare_hit_o(compare_hit_o));

// *** dv/act_core_model.sv ***
// Behavioural converter core answering start requests
`timescale 1ns/1ps

module act_core_model
	import act_pkg::*;
#(
	parameter int LAT = 20
)
(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire act_core_req_t req_i,
	input  wire logic [11:0]   value_i,
	output act_core_rsp_t      rsp_o
);
	int          cnt_ff;
	logic [11:0] last_ff;

	// Result is valid only with done; inverted otherwise so no stale match
	always_ff @(posedge clk_i) begin
		rsp_o.done <= 1'b0;
		rsp_o.result <= ~last_ff;
		if (rst_i) begin
			cnt_ff <= 0;
			last_ff <= 12'h000;
		end else if (req_i.start && req_i.core_enable) begin
			cnt_ff <= LAT;
		end else if (cnt_ff == 1) begin
			cnt_ff <= 0;
			rsp_o.done <= 1'b1;
			rsp_o.result <= value_i;
			last_ff <= value_i;
		end else if (cnt_ff > 0) begin
			cnt_ff <= cnt_ff - 1;
		end
	end
endmodule : act_core_model

// *** dv/act_top_tb.sv ***
// Testbench of the converter control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

module act_top_tb
	import act_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]    adr = 8'h00, q;
	logic [31:0]   dat = 32'h0000_0000, dat_o;
	logic [3:0]    flags = 4'h0;
	logic [11:0]   value = 12'h000;
	logic          ack_o, err_o, conv_clk_o, conversion_done_o, compare_hit_o;
	logic          e;
	act_core_req_t core_req_o;
	act_core_rsp_t core_rsp;
	act_analog_t   analog_o;
	int failures = 0, n_checks = 0, n_starts = 0, cyc_n = 0, t_start = 0;
	logic [7:0] ofs [5] = '{ACT_OFS_CTRL0, ACT_OFS_SRCCLK, ACT_OFS_AMPREF,
		ACT_OFS_TRIG, ACT_OFS_DELAY};
	logic [7:0] msk [5] = '{8'h00, 8'hE7, 8'h9F, 8'hFB, 8'hFF};
	logic [7:0] tv [7] = '{8'h80, 8'hC0, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hE1};
	logic [3:0] rv [7] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h4};
	logic [7:0] dv [7] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

	act_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
		.ack_o(ack_o), .err_o(err_o), .pwm_period_flag_i(flags[0]),
		.pwm_duty_flag_i(flags[3:1]), .core_rsp_i(core_rsp),
		.core_req_o(core_req_o), .analog_o(analog_o),
		.conv_clk_o(conv_clk_o), .conversion_done_o(conversion_done_o),
		.compare_hit_o(compare_hit_o));
	act_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(core_req_o),
		.value_i(value), .rsp_o(core_rsp));

	// ------------------------------------------------------------------
	// Clock, cycle count and start monitor
	// ------------------------------------------------------------------
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (core_req_o.start === 1'b1) begin
			n_starts <= n_starts + 1;
			t_start <= cyc_n;
		end
	end

	task conclude;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// Classic cycle: hold everything until ack or err is sampled
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h00_0000, d};
		for (i = 0; i < 64; i++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1 || err_o === 1'b1) break;
		end
		if (i == 64) begin failures++; conclude(); end
		q = dat_o[7:0];
		e = err_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task rd(input logic [7:0] a, input logic [7:0] x);
		wb(1'b0, a, 8'h00);
		`CHK(q, x)
	endtask : rd

	task wait_done;
		int i;
		for (i = 0; i < 512; i++) begin
			@(posedge clk_i);
			if (conversion_done_o === 1'b1) break;
		end
		if (i == 512) begin failures++; conclude(); end
	endtask : wait_done

	// Software start pulse, then completion, hit and status
	task conv(input logic [11:0] r, input logic j, input logic h);
		int s;
		s = n_starts;
		value <= r;
		wb(1'b1, ACT_OFS_CTRL0, {3'h5, j, 4'h0});
		repeat (2) @(posedge clk_i);
		`CHK(n_starts, s)
		wb(1'b1, ACT_OFS_CTRL0, {3'h1, j, 4'h0});
		rd(ACT_OFS_CTRL0, {3'h3, j, 4'h0});
		`CHK(n_starts, s + 1)
		wait_done();
		`CHK(compare_hit_o, h)
		rd(ACT_OFS_CTRL0, {3'h1, j, 4'h0});
		rd(ACT_OFS_STATUS, {6'h00, h, 1'b1});
		wb(1'b1, ACT_OFS_STATUS, 8'h03);
	endtask : conv

	initial begin
		int i, j, c, r, t0;
		logic p, lo, hi;
		logic [11:0] v [5];
		v = '{12'h080, 12'h100, 12'h400, 12'h800, 12'h900};
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 5; i++) rd(ofs[i], ACT_RST_BYTE);
		for (i = 1; i < 5; i++) wb(1'b1, ofs[i], 8'hFF);
		for (i = 1; i < 5; i++) rd(ofs[i], msk[i]);
		`CHK(analog_o.amp_ref_pin_on, 1'b0)
		`CHK(analog_o.bandgap_to_amp, 1'b1)
		`CHK(analog_o.channel_onehot, 10'h000)
		for (i = 1; i < 5; i++) wb(1'b1, ofs[i], 8'h00);
		wb(1'b0, 8'h30, 8'h00);
		`CHK(e, 1'b1)
		// Reference and gain codes
		for (c = 0; c < 4; c++) begin
			// Amplifier powered whenever it serves as the reference
			wb(1'b1, ACT_OFS_AMPREF, {c > 1, 2'h0, 5'(c * 5)});
			`CHK(analog_o.amp_enable, (c > 1))
			`CHK(analog_o.ext_ref_pin_on, (c == 1))
			`CHK(analog_o.gain_code, 2'(c))
		end
		for (c = 0; c < 16; c++) begin
			wb(1'b1, ACT_OFS_CTRL0, {4'h2, 4'(c)});
			`CHK(analog_o.channel_onehot, ((c == 0) || (c > 1 && c < 10)) ?
				10'(1 << c) : 10'h000)
		end
		wb(1'b1, ACT_OFS_CTRL0, 8'h29);
		for (c = 0; c < 8; c++) begin
			wb(1'b1, ACT_OFS_SRCCLK, {3'(c), 5'h00});
			`CHK(analog_o.source_code, 3'(c))
			`CHK(analog_o.channel_onehot, (c == 0) ? 10'h200 : 10'h000)
		end
		// Rising edges of the conversion clock over 256 cycles
		for (c = 0; c < 8; c++) begin
			wb(1'b1, ACT_OFS_SRCCLK, {5'h00, 3'(c)});
			repeat (4) @(posedge clk_i);
			p = conv_clk_o;
			r = 0;
			for (j = 0; j < 256; j++) begin
				@(posedge clk_i);
				if (conv_clk_o === 1'b1 && p === 1'b0) r++;
				p = conv_clk_o;
			end
			`CHK(r, (c == 0) ? 0 : (256 >> c))
		end
		conv(12'hABC, 1'b0, 1'b0);
		rd(ACT_OFS_RES_HI, 8'hAB);
		rd(ACT_OFS_RES_LO, 8'hC0);
		conv(12'hABC, 1'b1, 1'b0);
		rd(ACT_OFS_RES_HI, 8'h0A);
		rd(ACT_OFS_RES_LO, 8'hBC);
		// Bounds 0x100 and 0x800, right aligned, every mode and side
		wb(1'b1, ACT_OFS_SRCCLK, 8'h20);
		wb(1'b1, ACT_OFS_LOWB_HI, 8'h01);
		wb(1'b1, ACT_OFS_HIGHB_HI, 8'h08);
		rd(ACT_OFS_LOWB_HI, 8'h01);
		rd(ACT_OFS_HIGHB_HI, 8'h08);
		for (c = 0; c < 4; c++) begin
			wb(1'b1, ACT_OFS_TRIG, {3'h0, 2'(c), 3'h0});
			for (i = 0; i < 5; i++) begin
				lo = (v[i] <= 12'h100);
				hi = (v[i] >= 12'h800);
				conv(v[i], 1'b1, (c == 0) ? (!lo && !hi) : (c == 1) ? lo :
					(c == 2) ? hi : (lo || hi));
			end
		end
		wb(1'b1, ACT_OFS_SRCCLK, 8'h00);
		conv(12'h900, 1'b1, 1'b0);
		// PWM events: unselected flags first, then the selected one
		for (i = 0; i < 7; i++) begin
			wb(1'b1, ACT_OFS_DELAY, dv[i]);
			wb(1'b1, ACT_OFS_TRIG, tv[i]);
			r = n_starts;
			flags <= ~rv[i];
			repeat (12) @(posedge clk_i);
			`CHK(n_starts, r)
			flags <= 4'hF;
			t0 = cyc_n;
			wait_done();
			`CHK(t_start - t0, 2 + int'(dv[i]))
			`CHK(n_starts, r + 1)
			flags <= 4'h0;
			wb(1'b1, ACT_OFS_STATUS, 8'h03);
		end
		conclude();
	end
endmodule : act_top_tb
